// ### hw/bit_flags_pkg.sv
/*
  constants for the built-in-test flag word generator: timing, word
  numbers, flag positions, sensor fault masks and output limits.
  assumes a 10 MHz system clock and fixed-point sensor values.
*/
package bit_flags_pkg;

  // clock and scheduler timing
  localparam int unsigned CLK_PERIOD_NS  = 100;        // 10 MHz system clock
  localparam int unsigned SLOT_PERIOD_NS = 1000000;    // nominal slot, 1 ms
  localparam int unsigned SLOT_EXTEND_NS = 500000;     // added per overrun
  localparam int unsigned SLOT_CYCLES    = SLOT_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned SLOT_EXT_CYC   = SLOT_EXTEND_NS / CLK_PERIOD_NS;
  localparam logic [15:0] SLOT_LEN_MAX   = 16'hffff;   // extension saturates here
  localparam logic [2:0]  SLOTS_PER_MSG  = 3'h5;       // one message per five slots

  // message word numbers of the two fault words
  localparam logic [5:0]  WORD_STARTUP   = 6'h1e;      // word 30
  localparam logic [5:0]  WORD_OPERATION = 6'h1f;      // word 31

  // startup word bit positions
  localparam int unsigned SU_CODE_CSUM   = 0;
  localparam int unsigned SU_CAL_CSUM    = 1;
  localparam int unsigned SU_SENSOR      = 2;
  localparam int unsigned SU_PROC        = 3;
  localparam int unsigned SU_CAL_VALUE   = 4;

  // operation word bit positions
  localparam int unsigned OP_REG_VOLT    = 0;
  localparam int unsigned OP_SLOT_EXT    = 1;
  localparam int unsigned OP_MSG_MISSED  = 2;
  localparam int unsigned OP_PERIPH      = 3;
  localparam int unsigned OP_SENSOR      = 4;
  localparam int unsigned OP_CLAMP       = 5;
  localparam int unsigned OP_PLAUS       = 6;

  // word reset values
  localparam logic [15:0] STARTUP_RST    = 16'h0000;
  localparam logic [6:0]  OP_ACC_RST     = 7'h00;
  localparam logic [15:0] WORD_RST       = 16'h0000;

  // split of each 32-bit sensor fault array into startup and runtime flags
  localparam logic [31:0] SENSOR_STARTUP_MASK = 32'h0000_ffff;
  localparam logic [31:0] SENSOR_RUNTIME_MASK = 32'hffff_0000;

  // items owned by each sensor array: rate, accel, delta theta, delta vel
  localparam logic [15:0] SENSOR_ITEMS_X = 16'h0303;
  localparam logic [15:0] SENSOR_ITEMS_Y = 16'h0c0c;
  localparam logic [15:0] SENSOR_ITEMS_Z = 16'h3030;

  // output limits, signed fixed point in hundredths of unit
  localparam logic signed [31:0] RATE_LIMIT  = 32'sh0000_7724;  // 305.00 deg/s
  localparam logic signed [31:0] ACCEL_LIMIT = 32'sh0000_03e9;  // 10.01 g

  // regulator window and redundant accel tolerance
  localparam logic [11:0] REG_VOLT_MIN   = 12'h800;
  localparam logic [11:0] REG_VOLT_MAX   = 12'hc00;
  localparam logic [32:0] PLAUS_LIMIT    = 33'h0_0000_0032;  // 0.50 g

endpackage : bit_flags_pkg

// ### hw/accel_pair_check.sv
/*
  compares an accelerometer reading with its redundant partner on the
  same axis and flags a difference beyond tolerance.
  assumes both readings arrive together with the sample strobe.
*/
`timescale 1ns/1ps
`default_nettype none

module accel_pair_check (
  // clock and reset
  input  wire logic               sys_clk_i,
  input  wire logic               nrst_i,
  // readings
  input  wire logic               sample_i,
  input  wire logic               partner_present_i,
  input  wire logic signed [31:0] primary_i,
  input  wire logic signed [31:0] partner_i,
  // verdict
  output logic                    implausible_o
);
  import bit_flags_pkg::*;

  logic signed [32:0] diff;   // widened so the subtraction cannot wrap
  logic        [32:0] mag;    // absolute difference

  // magnitude of the disagreement
  always_comb begin
    diff = 33'(primary_i) - 33'(partner_i);
    mag  = diff[32] ? 33'(-diff) : 33'(diff);
  end

  // verdict is held until the next sample, axes without a partner never flag
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      implausible_o <= 1'b0;
    end else if (sample_i) begin
      implausible_o <= partner_present_i && (mag > PLAUS_LIMIT);
    end
  end

endmodule : accel_pair_check
`default_nettype wire

// ### hw/imu_builtin_test_flag_words.sv
/*
  built-in-test flag words of the periodic output message: a sticky
  startup word, a per-message operation word and the item error word,
  plus the slot scheduler that paces messages and the output clamp.
  assumes fault inputs are synchronous pulses or levels and that the
  serial transmitter reports its busy state on tx_busy_i.
*/
`timescale 1ns/1ps
`default_nettype none

module imu_builtin_test_flag_words #(
  parameter int unsigned SLOT_CYC = bit_flags_pkg::SLOT_CYCLES,   // slot length
  parameter int unsigned EXT_CYC  = bit_flags_pkg::SLOT_EXT_CYC   // overrun step
) (
  // clock and reset
  input  wire logic                    sys_clk_i,
  input  wire logic                    nrst_i,
  // initialisation checks
  input  wire logic                    init_active_i,
  input  wire logic                    code_checksum_fail_i,
  input  wire logic                    calibration_store_check_failed_i,
  input  wire logic                    internal_hw_error_i,
  input  wire logic                    calibration_value_invalid_i,
  input  wire logic [15:0]             calib_item_mask_i,
  // sensor fault arrays, x y z
  input  wire logic [2:0][31:0]        sensor_fault_i,
  // runtime checks
  input  wire logic                    reg_volt_valid_i,
  input  wire logic [11:0]             reg_volt_i,
  input  wire logic                    slot_overrun_i,
  input  wire logic                    periph_timeout_i,
  input  wire logic [15:0]             periph_item_mask_i,
  input  wire logic                    tx_busy_i,
  // sensor samples: x rate, x acc, y rate, y acc, z rate, z acc
  input  wire logic                    sample_valid_i,
  input  wire logic signed [5:0][31:0] axis_value_i,
  input  wire logic signed [2:0][31:0] accel_partner_i,
  input  wire logic [2:0]              partner_present_i,
  // message word read
  input  wire logic [5:0]              word_sel_i,
  // results
  output logic                         msg_send_o,
  output logic [15:0]                  startup_word_o,
  output logic [15:0]                  operation_word_o,
  output logic [15:0]                  item_error_word_o,
  output logic [15:0]                  word_data_o,
  output logic signed [5:0][31:0]      axis_out_o,
  output logic [15:0]                  slot_period_o
);
  import bit_flags_pkg::*;

  localparam logic [15:0] SLOT_LEN_RST = SLOT_CYC[15:0];  // nominal slot in cycles
  localparam logic [15:0] SLOT_STEP    = EXT_CYC[15:0];   // extension step

  // startup state, sticky for the power cycle
  logic [4:0]  su_flags_q;        // startup word bits 4..0
  logic [15:0] su_items_q;        // items marked by startup faults
  // operation state gathered between messages
  logic [6:0]  op_acc_q;          // pending operation flags
  logic [15:0] op_items_q;        // pending item marks
  logic [15:0] op_word_q;         // word of the last message
  logic [15:0] op_item_word_q;    // runtime items of the last message
  // scheduler
  logic [15:0] slot_cnt_q;        // cycle within slot
  logic [15:0] slot_len_q;        // current slot length
  logic [2:0]  slot_idx_q;        // slot within message period
  logic        send_q;            // message strobe
  logic        slot_ext_q;        // slot has been widened at least once
  // word read
  logic [15:0] word_data_q;

  // combinational events
  logic [31:0] sensor_init_fault_any;     // startup flags over all arrays
  logic [31:0] sensor_runtime_fault_any;  // runtime flags over all arrays
  logic [15:0] sensor_init_items;
  logic [15:0] sensor_runtime_items;
  logic        sensor_init_fault;
  logic        sensor_runtime_fault;
  logic        volt_bad;
  logic [5:0]  output_clamped;            // per axis clamp this sample
  logic [2:0]  accel_implausible;         // per accel axis verdict
  logic [15:0] clamp_items;
  logic [15:0] plaus_items;
  logic [6:0]  op_events;
  logic [15:0] op_item_events;
  logic        slot_end;
  logic        send_due;
  logic        send_fire;
  logic        send_skip;
  logic [16:0] slot_len_sum;

  // fold the three sensor arrays and map them onto their items
  always_comb begin
    sensor_init_fault_any    = 32'h0000_0000;
    sensor_runtime_fault_any = 32'h0000_0000;
    sensor_init_items        = 16'h0000;
    sensor_runtime_items     = 16'h0000;
    for (int a = 0; a < 3; a++) begin
      sensor_init_fault_any    = sensor_init_fault_any |
                                 (sensor_fault_i[a] & SENSOR_STARTUP_MASK);
      sensor_runtime_fault_any = sensor_runtime_fault_any |
                                 (sensor_fault_i[a] & SENSOR_RUNTIME_MASK);
      if (|(sensor_fault_i[a] & SENSOR_STARTUP_MASK)) begin
        sensor_init_items = sensor_init_items | (a == 0 ? SENSOR_ITEMS_X :
                            (a == 1 ? SENSOR_ITEMS_Y : SENSOR_ITEMS_Z));
      end
      if (|(sensor_fault_i[a] & SENSOR_RUNTIME_MASK)) begin
        sensor_runtime_items = sensor_runtime_items | (a == 0 ? SENSOR_ITEMS_X :
                               (a == 1 ? SENSOR_ITEMS_Y : SENSOR_ITEMS_Z));
      end
    end
    sensor_init_fault    = |sensor_init_fault_any;
    sensor_runtime_fault = |sensor_runtime_fault_any;
  end

  // startup word: only written while initialising, never cleared after
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      su_flags_q <= STARTUP_RST[4:0];
    end else if (init_active_i) begin
      // or-in only, so nothing can drop a set flag
      if (code_checksum_fail_i)             su_flags_q[SU_CODE_CSUM] <= 1'b1;
      if (calibration_store_check_failed_i) su_flags_q[SU_CAL_CSUM]  <= 1'b1;
      if (sensor_init_fault)                su_flags_q[SU_SENSOR]    <= 1'b1;
      if (internal_hw_error_i)              su_flags_q[SU_PROC]      <= 1'b1;
      if (calibration_value_invalid_i)      su_flags_q[SU_CAL_VALUE] <= 1'b1;
    end
  end

  // items hit by startup faults stay marked with their flags
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      su_items_q <= WORD_RST;
    end else if (init_active_i) begin
      su_items_q <= su_items_q | sensor_init_items |
                    (calibration_value_invalid_i ? calib_item_mask_i : 16'h0000);
    end
  end

  // regulator window check
  assign volt_bad = reg_volt_valid_i &&
                    ((reg_volt_i < REG_VOLT_MIN) || (reg_volt_i > REG_VOLT_MAX));

  // per axis clamp; even axes are rates, odd axes accelerations
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_axis
      localparam logic signed [31:0] LIM = (g % 2 == 1) ? ACCEL_LIMIT : RATE_LIMIT;
      // a slice of a packed array is unsigned, so re-sign it before comparing
      logic signed [31:0] val;
      assign val = axis_value_i[g];
      assign output_clamped[g] = sample_valid_i && ((val > LIM) || (val < -LIM));

      // clamped value held until the next sample
      always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          axis_out_o[g] <= 32'sh0000_0000;
        end else if (sample_valid_i) begin
          if (val > LIM) begin
            axis_out_o[g] <= LIM;
          end else if (val < -LIM) begin
            axis_out_o[g] <= -LIM;
          end else begin
            axis_out_o[g] <= axis_value_i[g];
          end
        end
      end

      chk_clamp_bound: assert property (
        @(posedge sys_clk_i) disable iff (!nrst_i)
        sample_valid_i |=> ($signed(axis_out_o[g]) <= LIM) && ($signed(axis_out_o[g]) >= -LIM))
        else $error("clamped output outside its limit");
    end

    // redundant accelerometer comparison, one per axis
    for (g = 0; g < 3; g++) begin : g_plaus
      accel_pair_check u_pair (
        .sys_clk_i         (sys_clk_i),
        .nrst_i            (nrst_i),
        .sample_i          (sample_valid_i),
        .partner_present_i (partner_present_i[g]),
        .primary_i         (axis_value_i[2*g+1]),
        .partner_i         (accel_partner_i[g]),
        .implausible_o     (accel_implausible[g])
      );
    end
  endgenerate

  // item bit n stands for message item n+2, axis k is item k+2
  assign clamp_items = {10'h000, output_clamped};
  assign plaus_items = {10'h000, accel_implausible[2], 1'b0,
                        accel_implausible[1], 1'b0, accel_implausible[0], 1'b0};

  // runtime events of this cycle, none counted while initialising
  always_comb begin
    op_events      = 7'h00;
    op_item_events = 16'h0000;
    if (!init_active_i) begin
      op_events[OP_REG_VOLT]   = volt_bad;
      op_events[OP_SLOT_EXT]   = slot_overrun_i || slot_ext_q;
      op_events[OP_MSG_MISSED] = send_skip;
      op_events[OP_PERIPH]     = periph_timeout_i;
      op_events[OP_SENSOR]     = sensor_runtime_fault;
      op_events[OP_CLAMP]      = |output_clamped;
      op_events[OP_PLAUS]      = |accel_implausible;
      op_item_events = (periph_timeout_i ? periph_item_mask_i : 16'h0000) |
                       sensor_runtime_items | clamp_items | plaus_items;
    end
  end

  // scheduler timing
  assign slot_end     = (slot_cnt_q == slot_len_q - 16'h0001);
  assign send_due     = slot_end && (slot_idx_q == SLOTS_PER_MSG - 3'h1) && !init_active_i;
  assign send_fire    = send_due && !tx_busy_i;
  assign send_skip    = send_due && tx_busy_i;
  assign slot_len_sum = {1'b0, slot_len_q} + {1'b0, SLOT_STEP};

  // slot length widens on each overrun after initialisation and stays wide; saturates
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      slot_len_q <= SLOT_LEN_RST;
      slot_ext_q <= 1'b0;
    end else if (slot_overrun_i && !init_active_i) begin
      slot_len_q <= slot_len_sum[16] ? SLOT_LEN_MAX : slot_len_sum[15:0];
      slot_ext_q <= 1'b1;
    end
  end

  // slot and message period counters
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      slot_cnt_q <= 16'h0000;
      slot_idx_q <= 3'h0;
    end else if (slot_end || slot_cnt_q >= slot_len_q) begin
      slot_cnt_q <= 16'h0000;
      slot_idx_q <= (slot_idx_q >= SLOTS_PER_MSG - 3'h1) ? 3'h0 : slot_idx_q + 3'h1;
    end else begin
      slot_cnt_q <= slot_cnt_q + 16'h0001;
    end
  end

  // accumulate between messages; a sent message restarts collection
  // and an event in the same cycle is kept, never dropped
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      op_acc_q   <= OP_ACC_RST;
      op_items_q <= WORD_RST;
    end else if (send_fire) begin
      op_acc_q   <= OP_ACC_RST;
      op_items_q <= WORD_RST;
    end else begin
      op_acc_q   <= op_acc_q | op_events;
      op_items_q <= op_items_q | op_item_events;
    end
  end

  // words frozen for the message being sent
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      op_word_q      <= WORD_RST;
      op_item_word_q <= WORD_RST;
      send_q         <= 1'b0;
    end else begin
      send_q <= send_fire;
      if (send_fire) begin
        op_word_q      <= {9'h000, op_acc_q | op_events};
        op_item_word_q <= op_items_q | op_item_events;
      end
    end
  end

  // message word read, only the two fault words are held here
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      word_data_q <= WORD_RST;
    end else if (word_sel_i == WORD_STARTUP) begin
      word_data_q <= {11'h000, su_flags_q};
    end else if (word_sel_i == WORD_OPERATION) begin
      word_data_q <= op_word_q;
    end else begin
      word_data_q <= WORD_RST;
    end
  end

  assign msg_send_o        = send_q;
  assign startup_word_o    = {11'h000, su_flags_q};
  assign operation_word_o  = op_word_q;
  assign item_error_word_o = su_items_q | op_item_word_q;
  assign word_data_o       = word_data_q;
  assign slot_period_o     = slot_len_q;

  chk_startup_sticky: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    ($past(startup_word_o) & ~startup_word_o) == 16'h0000)
    else $error("startup flag cleared");

  chk_code_checksum: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    init_active_i && code_checksum_fail_i |=> startup_word_o[SU_CODE_CSUM] [*8])
    else $error("code checksum flag not held");

  chk_cal_checksum: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    init_active_i && calibration_store_check_failed_i |=> startup_word_o[SU_CAL_CSUM])
    else $error("calibration checksum flag missing");

  chk_sensor_init: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    init_active_i && |(sensor_fault_i[0] & SENSOR_STARTUP_MASK)
    |=> startup_word_o[SU_SENSOR] && ((item_error_word_o & SENSOR_ITEMS_X) == SENSOR_ITEMS_X))
    else $error("sensor startup fault not flagged");

  chk_spare_zero: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (startup_word_o[15:5] == 11'h000) && (operation_word_o[15:7] == 9'h000))
    else $error("spare bit set");

  chk_volt_report: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    volt_bad && !init_active_i
    |=> (msg_send_o ? operation_word_o[OP_REG_VOLT] : op_acc_q[OP_REG_VOLT]))
    else $error("regulator fault not reported");

  chk_slot_extend: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    slot_overrun_i && !init_active_i && (slot_len_q < SLOT_LEN_MAX - SLOT_STEP)
    |=> slot_period_o == $past(slot_len_q) + SLOT_STEP)
    else $error("slot period not widened");

  chk_missed_flag: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    send_skip |=> op_acc_q[OP_MSG_MISSED] && !msg_send_o)
    else $error("skipped message not recorded");

  chk_op_fresh: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    send_fire && (op_events == 7'h00) |=> (op_acc_q == 7'h00) && msg_send_o)
    else $error("operation flags carried past message");

  chk_word_select: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    word_sel_i == WORD_OPERATION && !send_fire |=> word_data_o == operation_word_o)
    else $error("word 31 not the operation word");

endmodule : imu_builtin_test_flag_words
`default_nettype wire

// ### sim/serial_tx_model.sv
/*
  transmitter and host end of the serial message link.
  assumes one message leaves per send pulse; stall_i keeps the line busy.
*/
`timescale 1ns/1ps
`default_nettype none

module serial_tx_model #(
  parameter int unsigned BUSY_CYC = 30  // wire time of one message
) (
  // clock and reset
  input  wire logic sys_clk_i,
  input  wire logic nrst_i,
  // link
  input  wire logic msg_send_i,
  input  wire logic stall_i,
  output logic      tx_busy_o
);
  logic [7:0] busy_cnt_q;  // cycles left of the message on the wire

  // reload on each send, then count down to idle
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) busy_cnt_q <= 8'h00;
    else if (msg_send_i) busy_cnt_q <= BUSY_CYC[7:0];
    else if (busy_cnt_q != 8'h00) busy_cnt_q <= busy_cnt_q - 8'h01;
  end

  // a stalled host keeps the transmitter busy past the send time
  assign tx_busy_o = stall_i | (busy_cnt_q != 8'h00);
endmodule : serial_tx_model
`default_nettype wire

// ### sim/test_imu_builtin_test_flag_words.sv
/*
  self-checking bench for the built-in-test flag words.
  assumes short slots (20 cycles, step 10) so a message comes every 100.
*/
`timescale 1ns/1ps
`default_nettype none

module test_imu_builtin_test_flag_words;
  logic                    sys_clk_i = 1'b0;
  logic                    nrst_i    = 1'b0;
  logic                    init      = 1'b1;   // initialising
  logic [4:0]              su        = 5'h00;  // startup fault strobes
  logic [2:0][31:0]        sf        = '0;     // sensor fault arrays
  logic                    vv        = 1'b0;   // regulator strobe
  logic [11:0]             volt      = 12'h900;
  logic                    ovr       = 1'b0;   // slot overrun
  logic                    pto       = 1'b0;   // peripheral timeout
  logic                    sv        = 1'b0;   // sample strobe
  logic signed [5:0][31:0] ax        = '0;
  logic signed [2:0][31:0] pa        = '0;
  logic [2:0]              pres      = 3'h0;
  logic [5:0]              sel       = 6'h00;
  logic                    stall     = 1'b0;   // slow host
  logic                    busy;
  logic                    msg;
  logic [15:0]             suw, opw, iew, wd, slot;
  logic signed [5:0][31:0] axo;
  int                      errors      = 0;
  int                      comparisons = 0;
  int                      cyc         = 0;

  // masks tied: only their routing into the item word is of interest
  imu_builtin_test_flag_words #(.SLOT_CYC(20), .EXT_CYC(10)) uut (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .init_active_i(init),
    .code_checksum_fail_i(su[0]), .calibration_store_check_failed_i(su[1]),
    .internal_hw_error_i(su[3]), .calibration_value_invalid_i(su[4]),
    .calib_item_mask_i(16'h0080), .sensor_fault_i(sf | 96'(su[2])),
    .reg_volt_valid_i(vv), .reg_volt_i(volt), .slot_overrun_i(ovr),
    .periph_timeout_i(pto), .periph_item_mask_i(16'h4000), .tx_busy_i(busy),
    .sample_valid_i(sv), .axis_value_i(ax), .accel_partner_i(pa),
    .partner_present_i(pres), .word_sel_i(sel), .msg_send_o(msg),
    .startup_word_o(suw), .operation_word_o(opw), .item_error_word_o(iew),
    .word_data_o(wd), .axis_out_o(axo), .slot_period_o(slot));

  serial_tx_model #(.BUSY_CYC(30)) host (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .msg_send_i(msg), .stall_i(stall), .tx_busy_o(busy));

  initial forever #50 sys_clk_i = ~sys_clk_i;

  // hang guard: run needs about 2000 cycles
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      errors++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // bounded wait for the send pulse, sampled after the edge settles
  task automatic wait_msg();
    for (int i = 0; i < 400; i++) begin
      @(posedge sys_clk_i);
      #1;
      if (msg === 1'b1) return;
    end
    check(32'h0, 32'h1);
  endtask : wait_msg

  task automatic expect_op(input logic [15:0] exp);
    wait_msg();
    check(32'(opw), 32'(exp));
  endtask : expect_op

  task automatic sample(input logic signed [31:0] r, a, p, input logic [2:0] pr);
    @(posedge sys_clk_i);
    ax[0] <= r;
    ax[1] <= a;
    pa[0] <= p;
    pres <= pr;
    sv <= 1'b1;
    @(posedge sys_clk_i);
    sv <= 1'b0;
    #1;
  endtask : sample

  task automatic read_word(input logic [5:0] s, input logic [15:0] exp);
    @(posedge sys_clk_i);
    sel <= s;
    repeat (2) @(posedge sys_clk_i);
    #1;
    check(32'(wd), 32'(exp));
  endtask : read_word

  // one startup fault at a time, word must grow and never shrink
  task automatic startup_flags();
    for (int i = 0; i < 5; i++) begin
      @(posedge sys_clk_i);
      su <= 5'h01 << i;
      @(posedge sys_clk_i);
      su <= 5'h00;
      @(posedge sys_clk_i);
      #1;
      check(32'(suw), (32'h2 << i) - 32'h1);
    end
    check(32'(iew & 16'h0383), 32'h0383);
    @(posedge sys_clk_i);
    init <= 1'b0;
    wait_msg();
    check(32'(suw), 32'h001f);
    expect_op(16'h0000);
  endtask : startup_flags

  task automatic periph_case();
    @(posedge sys_clk_i);
    pto <= 1'b1;
    @(posedge sys_clk_i);
    pto <= 1'b0;
    expect_op(16'h0008);
    check(32'(iew & 16'h4000), 32'h4000);
    expect_op(16'h0000);
    check(32'(iew & 16'h4000), 32'h0);
  endtask : periph_case

  // lower window edge is legal, one step above the top is not
  task automatic volt_case();
    for (int i = 0; i < 2; i++) begin
      @(posedge sys_clk_i);
      vv <= 1'b1;
      volt <= (i == 0) ? 12'h800 : 12'hc01;
      @(posedge sys_clk_i);
      vv <= 1'b0;
      expect_op(16'(i));
    end
  endtask : volt_case

  task automatic sensor_case();
    @(posedge sys_clk_i);
    sf[2][16] <= 1'b1;
    @(posedge sys_clk_i);
    sf <= '0;
    expect_op(16'h0010);
    check(32'(iew & 16'h3030), 32'h3030);
  endtask : sensor_case

  task automatic clamp_case();
    sample(32'sd40000, -32'sd2000, 32'sd0, 3'h0);
    check(axo[0], 32'sd30500);
    check(axo[1], -32'sd1001);
    expect_op(16'h0020);
    check(32'(iew & 16'h0003), 32'h0003);
  endtask : clamp_case

  // unpaired axis is never judged; the residue message is discarded
  task automatic plaus_case();
    sample(32'sd0, 32'sd100, -32'sd100, 3'h0);
    expect_op(16'h0000);
    sample(32'sd0, 32'sd100, -32'sd100, 3'h1);
    expect_op(16'h0040);
    check(32'(iew & 16'h0002), 32'h0002);
    sample(32'sd0, 32'sd0, 32'sd0, 3'h0);
    wait_msg();
  endtask : plaus_case

  task automatic busy_case();
    @(posedge sys_clk_i);
    stall <= 1'b1;
    repeat (120) @(posedge sys_clk_i);
    stall <= 1'b0;
    expect_op(16'h0004);
  endtask : busy_case

  task automatic overrun_case();
    int t0;
    @(posedge sys_clk_i);
    ovr <= 1'b1;
    @(posedge sys_clk_i);
    ovr <= 1'b0;
    expect_op(16'h0002);
    check(32'(slot), 32'd30);
    wait_msg();
    t0 = cyc;
    expect_op(16'h0002);
    check(32'(cyc - t0), 32'd150);
    read_word(6'h1e, 16'h001f);
    read_word(6'h1f, 16'h0002);
    read_word(6'h00, 16'h0000);
  endtask : overrun_case

  task automatic tally_and_finish();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (8) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    startup_flags();
    periph_case();
    volt_case();
    sensor_case();
    clamp_case();
    plaus_case();
    busy_case();
    overrun_case();
    tally_and_finish();
  end
endmodule : test_imu_builtin_test_flag_words
`default_nettype wire
